//--- core/core_interrupt_sources.sv
// Purpose: Interrupt sources, wake-up and vectoring for an 8-bit core.
// Assumes: ref_clk is the instruction clock; core hands over at boundaries.
// Notes:   Register port is plain strobes; read data valid the next cycle.
//
// Function
// - The external pin triggers on a rising edge when edge select is one, else falling.
// - A selected edge on the external pin sets the external pin flag, control bit one.
// - The external pin request is suppressed while its enable, control bit four, is clear.
// - Wake from sleep by the external pin only if its enable was set before sleep.
// - After an interrupt wake the vector 0004h is taken if global enable is set, else execution continues.
// - A timer count roll-over from FFh to 00h sets the timer overflow flag, control bit two.
// - The timer overflow request passes only while its enable, control bit five, is set.
// - Any level change on port pins seven to four sets the port change flag, control bit zero.
// - The port change request passes only while its own enable is set.
// - A wake by interrupt leaves the causing flag set so software can identify it.
// - Taking an interrupt pushes only the return program counter.
// - A port change coinciding with a port read may fail to set the port change flag.
`timescale 1ns/100ps
module core_interrupt_sources
  import irq_src_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [irq_src_pkg::ADDR_W-1:0] regAddr,
  input wire logic [irq_src_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [irq_src_pkg::DATA_W-1:0] regRdata,
  // Interrupt sources
  input wire logic ext_irq_pin,
  input wire logic [irq_src_pkg::PORT_W-1:0] port_b_pins,
  input wire logic portRead,
  input wire logic [irq_src_pkg::DATA_W-1:0] timer_zero_count,
  // Core sequencer
  input wire logic sleeping,
  input wire logic vectorAck,
  input wire logic [irq_src_pkg::PC_W-1:0] returnPc,
  output logic coreIrqReq,
  output logic wakeUp,
  output logic wakeToVector,
  output logic stackPush,
  output logic [irq_src_pkg::PC_W-1:0] stackPushData,
  output logic pcLoad,
  output logic [irq_src_pkg::PC_W-1:0] pcLoadValue,
  // Event interrupt
  output logic eventIrq
);

  // ---------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic edgeSel;
    logic [EV_W-1:0] evStatus;
    logic [EV_W-1:0] evMask;
    logic [DATA_W-1:0] prevTimer;
    logic prevPin;
    logic [2:0] settle;
    logic wasSleeping;
    logic [2:0] sleepEn;
    logic woke;
    logic wakeUp;
    logic wakeToVector;
    logic stackPush;
    logic [PC_W-1:0] stackPushData;
    logic pcLoad;
    logic [DATA_W-1:0] rdata;
  } top_state_t;

  top_state_t cur;
  top_state_t next_cur;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rstPipe;
  logic rstSync_n;

  // Release is synchronised so no flop sees a partial reset exit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstSync_n = rstPipe[1];

  // ---------------------------------------------------------------
  // Pin synchronisers and port change
  // ---------------------------------------------------------------
  logic [PORT_W:0] pinSync;
  logic extPinSync;
  logic [PORT_W-1:0] portSync;
  logic portChanged;
  logic [PORT_W-1:0] portLatch;

  pin_sync #(
    .WIDTH(PORT_W + 1)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rstSync_n(rstSync_n),
    .pinAsync({port_b_pins, ext_irq_pin}),
    .pinSync(pinSync)
  );

  assign extPinSync = pinSync[0];
  assign portSync = pinSync[PORT_W:1];

  port_change_detect u_port_change (
    .ref_clk(ref_clk),
    .rstSync_n(rstSync_n),
    .portPins(portSync),
    .portRead(portRead),
    .portChanged(portChanged),
    .portLatch(portLatch)
  );

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] src_flags(input logic [DATA_W-1:0] c);
    src_flags = {c[TIMER_ZERO_OVERFLOW_FLAG_BIT], c[EXT_PIN_FLAG_BIT],
                 c[PORT_CHANGE_FLAG_BIT]};
  endfunction : src_flags

  function automatic logic [2:0] src_enables(input logic [DATA_W-1:0] c);
    src_enables = {c[TIMER_ZERO_OVERFLOW_ENABLE_BIT], c[EXT_PIN_ENABLE_BIT],
                   c[PORT_CHANGE_ENABLE_BIT]};
  endfunction : src_enables

  function automatic logic reg_hit(input logic strobe,
                                   input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    reg_hit = strobe && (a == ofs);
  endfunction : reg_hit

  // ---------------------------------------------------------------
  // Source events
  // ---------------------------------------------------------------
  logic extEdge;
  logic timerOvf;
  logic [2:0] pending;
  logic anyPending;

  // Edge select steers which transition counts
  // Blocked until the pin history has filled, so a high pin gives no edge after reset
  assign extEdge = cur.settle[2] &&
                   (cur.edgeSel ? (extPinSync && !cur.prevPin)
                                : (!extPinSync && cur.prevPin));

  assign timerOvf = (cur.prevTimer == TIMER_MAX) &&
                    (timer_zero_count == TIMER_ZERO);

  // Each source gated by its own enable
  assign pending = src_flags(cur.ctrl) & src_enables(cur.ctrl);
  assign anyPending = |pending;

  // Level request to the core sequencer
  assign coreIrqReq = cur.ctrl[GLOBAL_IRQ_ENABLE_BIT] && anyPending;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic takeVector;
  logic sleepEntry;
  logic wakeNow;

  assign takeVector = coreIrqReq && vectorAck;
  assign sleepEntry = sleeping && !cur.wasSleeping;
  // Wake uses enables captured at sleep entry, not ones written later
  assign wakeNow = sleeping && cur.wasSleeping && !cur.woke &&
                   (|(src_flags(cur.ctrl) & cur.sleepEn));

  always_comb begin
    next_cur = cur;
    next_cur.prevTimer = timer_zero_count;
    next_cur.prevPin = extPinSync;
    next_cur.settle = {cur.settle[1:0], 1'b1};
    next_cur.wasSleeping = sleeping;
    next_cur.wakeUp = 1'b0;
    next_cur.wakeToVector = 1'b0;
    next_cur.stackPush = 1'b0;
    next_cur.pcLoad = 1'b0;
    next_cur.rdata = '0;

    // Software writes first, hardware sets override afterwards
    if (reg_hit(regWrite, regAddr, IRQ_CONTROL_OFS)) begin
      next_cur.ctrl = regWdata & IRQ_CONTROL_WMASK;
    end
    if (reg_hit(regWrite, regAddr, OPTION_OFS)) begin
      next_cur.edgeSel = regWdata[EXT_EDGE_SELECT_BIT];
    end
    if (reg_hit(regWrite, regAddr, EVENT_STATUS_OFS)) begin
      next_cur.evStatus = cur.evStatus & ~regWdata[EV_W-1:0];
    end
    if (reg_hit(regWrite, regAddr, EVENT_MASK_OFS)) begin
      next_cur.evMask = regWdata[EV_W-1:0];
    end

    // Flags are sticky; only software clears them
    if (extEdge) begin
      next_cur.ctrl[EXT_PIN_FLAG_BIT] = 1'b1;
      next_cur.evStatus[EV_EXT_EDGE] = 1'b1;
    end
    if (timerOvf) begin
      next_cur.ctrl[TIMER_ZERO_OVERFLOW_FLAG_BIT] = 1'b1;
      next_cur.evStatus[EV_TIMER_OVF] = 1'b1;
    end
    if (portChanged) begin
      next_cur.ctrl[PORT_CHANGE_FLAG_BIT] = 1'b1;
      next_cur.evStatus[EV_PORT_CHANGE] = 1'b1;
    end

    // Sleep entry snapshot of the enables
    if (sleepEntry) begin
      next_cur.sleepEn = src_enables(cur.ctrl);
      next_cur.woke = 1'b0;
    end
    if (!sleeping) begin
      next_cur.woke = 1'b0;
    end
    if (wakeNow) begin
      next_cur.woke = 1'b1;
      next_cur.wakeUp = 1'b1;
      next_cur.wakeToVector = cur.ctrl[GLOBAL_IRQ_ENABLE_BIT];
      next_cur.evStatus[EV_WAKE] = 1'b1;
    end

    // Vector take: only the return address is saved
    if (takeVector) begin
      next_cur.ctrl[GLOBAL_IRQ_ENABLE_BIT] = 1'b0;
      next_cur.stackPush = 1'b1;
      next_cur.stackPushData = returnPc;
      next_cur.pcLoad = 1'b1;
      next_cur.evStatus[EV_VECTOR] = 1'b1;
    end

    // Read data valid for one cycle only
    if (regRead) begin
      unique case (regAddr)
        IRQ_CONTROL_OFS: next_cur.rdata = cur.ctrl;
        OPTION_OFS: next_cur.rdata = DATA_W'({cur.edgeSel, 6'h00});
        EVENT_STATUS_OFS: next_cur.rdata = DATA_W'(cur.evStatus);
        EVENT_MASK_OFS: next_cur.rdata = DATA_W'(cur.evMask);
        PORT_LATCH_OFS: next_cur.rdata = DATA_W'({portLatch, 4'h0});
        default: next_cur.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cur <= '0;
      cur.ctrl <= IRQ_CONTROL_RESET;
      cur.edgeSel <= EXT_EDGE_SELECT_RESET;
      cur.evMask <= EVENT_MASK_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign regRdata = cur.rdata;
  assign wakeUp = cur.wakeUp;
  assign wakeToVector = cur.wakeToVector;
  assign stackPush = cur.stackPush;
  assign stackPushData = cur.stackPushData;
  assign pcLoad = cur.pcLoad;
  // Constant vector; no page latch involvement on entry
  assign pcLoadValue = IRQ_VECTOR;
  assign eventIrq = |(cur.evStatus & cur.evMask);

endmodule : core_interrupt_sources

//--- core/irq_src_pkg.sv
// Purpose: Shared constants for the interrupt source block.
// Assumes: 8-bit register port, 4-bit word address, 13-bit program counter.
// Notes:   Offsets and field positions are named once here.
package irq_src_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int PORT_W = 4;
  localparam int EV_W = 5;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IRQ_CONTROL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] OPTION_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] EVENT_STATUS_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] EVENT_MASK_OFS = 4'h3;
  localparam logic [ADDR_W-1:0] PORT_LATCH_OFS = 4'h4;

  // ---------------------------------------------------------------
  // irq_control_reg fields
  // ---------------------------------------------------------------
  localparam int PORT_CHANGE_FLAG_BIT = 0;
  localparam int EXT_PIN_FLAG_BIT = 1;
  localparam int TIMER_ZERO_OVERFLOW_FLAG_BIT = 2;
  localparam int PORT_CHANGE_ENABLE_BIT = 3;
  localparam int EXT_PIN_ENABLE_BIT = 4;
  localparam int TIMER_ZERO_OVERFLOW_ENABLE_BIT = 5;
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam logic [DATA_W-1:0] IRQ_CONTROL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_CONTROL_WMASK = 8'hbf;

  // ---------------------------------------------------------------
  // Option register field
  // ---------------------------------------------------------------
  localparam int EXT_EDGE_SELECT_BIT = 6;
  localparam logic EXT_EDGE_SELECT_RESET = 1'b1;

  // ---------------------------------------------------------------
  // Event status / mask fields
  // ---------------------------------------------------------------
  localparam int EV_PORT_CHANGE = 0;
  localparam int EV_EXT_EDGE = 1;
  localparam int EV_TIMER_OVF = 2;
  localparam int EV_WAKE = 3;
  localparam int EV_VECTOR = 4;
  localparam logic [EV_W-1:0] EVENT_MASK_RESET = 5'h00;

  // ---------------------------------------------------------------
  // Core constants
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [DATA_W-1:0] TIMER_MAX = 8'hff;
  localparam logic [DATA_W-1:0] TIMER_ZERO = 8'h00;

endpackage : irq_src_pkg

//--- core/pin_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin levels.
// Assumes: Inputs are quasi-static levels from outside the clock domain.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstSync_n,
  // Levels
  input wire logic [WIDTH-1:0] pinAsync,
  output logic [WIDTH-1:0] pinSync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t cur;
  sync_state_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.stage1 = pinAsync;
    next_cur.stage2 = cur.stage1;
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign pinSync = cur.stage2;

endmodule : pin_sync

//--- core/port_change_detect.sv
// Purpose: Mismatch detector for the upper port pins against a read latch.
// Assumes: Pins are already synchronised; portRead is a one-cycle strobe.
// Notes:   A read reloads the latch, so a change in that same cycle is absorbed.
`timescale 1ns/100ps
module port_change_detect
  import irq_src_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstSync_n,
  // Pins and core read strobe
  input wire logic [irq_src_pkg::PORT_W-1:0] portPins,
  input wire logic portRead,
  // Result
  output logic portChanged,
  output logic [irq_src_pkg::PORT_W-1:0] portLatch
);

  typedef struct packed {
    logic [PORT_W-1:0] latch;
    logic changed;
  } change_state_t;

  change_state_t cur;
  change_state_t next_cur;

  always_comb begin
    next_cur = cur;
    if (portRead) begin
      next_cur.latch = portPins;
      next_cur.changed = 1'b0;
    end else begin
      next_cur.changed = (portPins != cur.latch);
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign portChanged = cur.changed;
  assign portLatch = cur.latch;

endmodule : port_change_detect

//--- dv/core_interrupt_sources_bench.sv
// Purpose: Self-checking bench for the interrupt source block.
// Assumes: Core sequencer model on the far side; seed fixed at 50.
// Notes:   Flag timing waits cover the two-stage pin synchroniser.
`timescale 1ns/100ps
module core_interrupt_sources_bench;
  import irq_src_pkg::*;
  logic clk, reset_n, regWrite, regRead, portRead, extPin, ackEn, goSleep;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata, timerCount, en;
  logic [PORT_W-1:0] portPins, p;
  logic [3:0] ackDelay;
  logic sleeping, vectorAck, coreIrqReq, wakeUp, wakeToVector, stackPush, pcLoad, eventIrq;
  logic [PC_W-1:0] returnPc, stackPushData, pcLoadValue, ackPc;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 50;
  int k;
  core_interrupt_sources dut_u (.ref_clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .ext_irq_pin(extPin), .port_b_pins(portPins), .portRead(portRead),
    .timer_zero_count(timerCount), .sleeping(sleeping), .vectorAck(vectorAck),
    .returnPc(returnPc), .coreIrqReq(coreIrqReq), .wakeUp(wakeUp),
    .wakeToVector(wakeToVector), .stackPush(stackPush), .stackPushData(stackPushData),
    .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .eventIrq(eventIrq));
  core_seq_model core_u (.ref_clk(clk), .reset_n(reset_n), .ackEn(ackEn),
    .ackDelay(ackDelay), .goSleep(goSleep), .coreIrqReq(coreIrqReq), .wakeUp(wakeUp),
    .sleeping(sleeping), .vectorAck(vectorAck), .returnPc(returnPc));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string s);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk) regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] v, input string s);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk) regRead <= 1'b0;
    #1 check(regRdata, v, s);
  endtask : rd
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  always @(posedge clk) if (vectorAck) ackPc <= returnPc;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2000000;
    n_errors++;
    $display("wrong value at %0t: watchdog ran out", $time);
    results();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    {reset_n, regWrite, regRead, portRead, extPin, ackEn, goSleep} = '0;
    {regAddr, regWdata, timerCount, portPins, ackDelay} = '0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    idle(6);
    rd(IRQ_CONTROL_OFS, IRQ_CONTROL_RESET, "control reset");
    rd(OPTION_OFS, 8'h40, "option reset");
    rd(4'hf, 8'h00, "unmapped read");
    for (int es = 0; es < 2; es++) begin
      wr(OPTION_OFS, 8'(es << 6));
      extPin <= es[0];
      idle(6);
      wr(IRQ_CONTROL_OFS, 8'h00);
      extPin <= ~es[0];
      idle(6);
      rd(IRQ_CONTROL_OFS, 8'h00, "wrong edge");
      extPin <= es[0];
      idle(6);
      rd(IRQ_CONTROL_OFS, 8'h02, "selected edge");
    end
    $display("edge test done");
    wr(IRQ_CONTROL_OFS, 8'h00);
    repeat (20) @(posedge clk) timerCount <= 8'($random(seed)) & 8'h7f;
    rd(IRQ_CONTROL_OFS, 8'h00, "no roll-over");
    @(posedge clk) timerCount <= TIMER_MAX;
    @(posedge clk) timerCount <= TIMER_ZERO;
    idle(3);
    rd(IRQ_CONTROL_OFS, 8'h04, "roll-over");
    wr(IRQ_CONTROL_OFS, 8'h00);
    @(posedge clk) portRead <= 1'b1;
    @(posedge clk) portRead <= 1'b0;
    rd(PORT_LATCH_OFS, {portPins, 4'h0}, "port latch");
    p = 4'($random(seed)) | 4'h1;
    @(posedge clk) portPins <= portPins ^ p;
    idle(6);
    rd(IRQ_CONTROL_OFS, 8'h01, "port change");
    @(posedge clk) portRead <= 1'b1;
    @(posedge clk) portRead <= 1'b0;
    wr(IRQ_CONTROL_OFS, 8'h00);
    idle(6);
    rd(IRQ_CONTROL_OFS, 8'h00, "change absorbed");
    $display("source test done");
    for (int i = 0; i < 3; i++) begin
      en = 8'h08 << i;
      wr(IRQ_CONTROL_OFS, 8'h80 | (8'h01 << i) | (8'h38 & ~en));
      idle(1);
      check(coreIrqReq, 1'b0, "other enables");
      wr(IRQ_CONTROL_OFS, (8'h01 << i) | en);
      idle(1);
      check(coreIrqReq, 1'b0, "no global");
      wr(IRQ_CONTROL_OFS, 8'h80 | (8'h01 << i) | en);
      idle(1);
      check(coreIrqReq, 1'b1, "request");
    end
    ackDelay <= 4'($random(seed)) & 4'h7;
    ackEn <= 1'b1;
    k = 0;
    while (stackPush !== 1'b1 && k < 20) begin
      idle(1);
      k++;
    end
    check(stackPush, 1'b1, "push");
    check(stackPushData, ackPc, "push data");
    check(pcLoadValue, IRQ_VECTOR, "vector");
    ackEn <= 1'b0;
    rd(IRQ_CONTROL_OFS, 8'h24, "global cleared");
    wr(EVENT_MASK_OFS, 8'h10);
    idle(1);
    check(eventIrq, 1'b1, "event irq");
    wr(EVENT_STATUS_OFS, 8'h1f);
    idle(1);
    check(eventIrq, 1'b0, "event cleared");
    $display("vector test done");
    for (int g = 0; g < 3; g++) begin
      extPin <= 1'b0;
      wr(IRQ_CONTROL_OFS, g == 2 ? 8'h00 : 8'(g << 7) | 8'h10);
      idle(6);
      @(posedge clk) goSleep <= 1'b1;
      if (g == 2) wr(IRQ_CONTROL_OFS, 8'h10);
      idle(2);
      extPin <= 1'b1;
      k = 0;
      while (wakeUp !== 1'b1 && k < 12) begin
        idle(1);
        k++;
      end
      check(wakeUp, g < 2, "wake");
      if (g < 2) check(wakeToVector, g == 1, "wake vector");
      if (g < 2) rd(IRQ_CONTROL_OFS, 8'(g << 7) | 8'h12, "wake cause");
      @(posedge clk) goSleep <= 1'b0;
    end
    $display("sleep test done");
    results();
  end
endmodule : core_interrupt_sources_bench
bind core_interrupt_sources core_interrupt_sources_props props_u (.ref_clk(ref_clk),
  .reset_n(reset_n), .sleeping(sleeping), .vectorAck(vectorAck), .returnPc(returnPc),
  .coreIrqReq(coreIrqReq), .wakeUp(wakeUp), .wakeToVector(wakeToVector),
  .stackPush(stackPush), .stackPushData(stackPushData), .pcLoad(pcLoad),
  .pcLoadValue(pcLoadValue));

//--- dv/core_interrupt_sources_props.sv
// Purpose: Port-level checks for the interrupt source block.
// Assumes: Bound to core_interrupt_sources; one clock domain.
// Notes:   Enables are internal, so they are judged through the request.
`timescale 1ns/100ps
module core_interrupt_sources_props
  import irq_src_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Core side
  input wire logic sleeping,
  input wire logic vectorAck,
  input wire logic [irq_src_pkg::PC_W-1:0] returnPc,
  input wire logic coreIrqReq,
  input wire logic wakeUp,
  input wire logic wakeToVector,
  input wire logic stackPush,
  input wire logic [irq_src_pkg::PC_W-1:0] stackPushData,
  input wire logic pcLoad,
  input wire logic [irq_src_pkg::PC_W-1:0] pcLoadValue
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic take = vectorAck && coreIrqReq;
  a_take_push: assert property (take |=> stackPush && pcLoad)
    else $error("no push after vector take");
  a_push_data: assert property (take |=> stackPushData == $past(returnPc))
    else $error("pushed address differs");
  a_vector_addr: assert property (pcLoad |-> pcLoadValue == IRQ_VECTOR && $past(take))
    else $error("vector address wrong");
  a_push_pairs: assert property (stackPush == pcLoad)
    else $error("push and load apart");
  a_gie_clears: assert property (take |=> !coreIrqReq)
    else $error("request stays after take");
  a_push_single: assert property (stackPush |=> !stackPush)
    else $error("push longer than a cycle");
  a_wake_sleep: assert property (wakeUp |-> $past(sleeping))
    else $error("wake while awake");
  a_wake_once: assert property (wakeUp |=> !wakeUp)
    else $error("wake longer than a cycle");
  a_vec_wake: assert property (wakeToVector |-> wakeUp)
    else $error("vector flag without wake");
  c_take: cover property (take);
  c_wake_vec: cover property (wakeUp && wakeToVector);
  c_wake_cont: cover property (wakeUp && !wakeToVector);
endmodule : core_interrupt_sources_props

//--- dv/core_seq_model.sv
// Purpose: Behavioural core sequencer facing the interrupt block.
// Assumes: Same clock as the block; acks at instruction boundaries.
// Notes:   Ack delay is set by the bench to model slow instructions.
`timescale 1ns/100ps
module core_seq_model
  import irq_src_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Bench controls
  input wire logic ackEn,
  input wire logic [3:0] ackDelay,
  input wire logic goSleep,
  // Interrupt block
  input wire logic coreIrqReq,
  input wire logic wakeUp,
  output logic sleeping,
  output logic vectorAck,
  output logic [irq_src_pkg::PC_W-1:0] returnPc
);
  logic [3:0] waitCnt;
  logic woke;
  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt <= 4'h0;
      woke <= 1'b0;
      sleeping <= 1'b0;
      vectorAck <= 1'b0;
      returnPc <= '0;
    end else begin
      vectorAck <= 1'b0;
      // Handler keeps its own context; only the return address crosses over
      returnPc <= returnPc + 1'b1;
      // Only one ack per request; the block drops it after the take
      if (ackEn && coreIrqReq && !vectorAck && !sleeping) begin
        waitCnt <= waitCnt + 4'h1;
        if (waitCnt == ackDelay) begin
          vectorAck <= 1'b1;
          waitCnt <= 4'h0;
        end
      end else begin
        waitCnt <= 4'h0;
      end
      // Sleep ends on a wake; re-arming needs goSleep lowered
      if (!goSleep) begin
        sleeping <= 1'b0;
        woke <= 1'b0;
      end else if (wakeUp) begin
        sleeping <= 1'b0;
        woke <= 1'b1;
      end else if (!woke) begin
        sleeping <= 1'b1;
      end
    end
  end
endmodule : core_seq_model
